// File: logic/reset_timeout_pkg.sv
// Constants for the reset and start-up time-out sequencer.
// Assumes a 100 MHz system clock and an AXI4-Lite register bus.
package reset_timeout_pkg;
   // Register byte offsets
   localparam logic [3:0] OFF_CONFIG = 4'h0;
   localparam logic [3:0] OFF_STATUS = 4'h4;
   localparam logic [3:0] OFF_CAUSE  = 4'h8;
   // Config fields
   localparam int CFG_OSC_LO_BIT  = 0;
   localparam int CFG_OSC_HI_BIT  = 1;
   localparam int CFG_POWER_UP_TIMER_EN_BIT = 2;
   localparam int CFG_DROP_EN_BIT = 3;
   localparam logic [3:0] CFG_RESET = 4'h0;
   // Status fields
   localparam int ST_SUPPLY_BIT = 0;
   localparam int ST_POWER_BIT  = 1;
   localparam int ST_SLEEP_BIT  = 2;
   localparam int ST_EXPIRY_BIT = 3;
   localparam int ST_CORE_BIT   = 4;
   // Oscillator modes
   localparam logic [1:0] MODE_LP = 2'h0;
   localparam logic [1:0] MODE_XT = 2'h1;
   localparam logic [1:0] MODE_HS = 2'h2;
   localparam logic [1:0] MODE_RC = 2'h3;
   // Reset causes
   typedef enum logic [2:0]
   {
      CAUSE_POWER_ON   = 3'h0,
      CAUSE_CLR_RUN    = 3'h1,
      CAUSE_CLR_SLEEP  = 3'h2,
      CAUSE_WD_RESET   = 3'h3,
      CAUSE_WD_WAKE    = 3'h4,
      CAUSE_SUPPLY     = 3'h5
   } cause_t;
   // Timing
   localparam int CLK_MHZ           = 100;
   localparam int POWER_UP_DELAY_MS = 72;
   localparam int DROP_MIN_US       = 100;
   localparam int CLEAR_FILTER_NS   = 100;
   localparam int POWER_UP_CYCLES   = POWER_UP_DELAY_MS * 1000 * CLK_MHZ;
   localparam int DROP_MIN_CYCLES   = DROP_MIN_US * CLK_MHZ;
   localparam int CLEAR_FILTER_CYC  = (CLEAR_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int OSC_STARTUP_COUNT = 1024;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// File: logic/reset_timeout_sequencer.sv
// Reset source merge, power-up delay and oscillator start-up sequencing.
// Assumes sources synchronous to clk; rcTick and oscTick are one-cycle pulses.
// Functional notes
// - Record six distinct reset causes
// - Preserved state ignores every reset
// - Core state resets except watchdog wake
// - Filter discards short master-clear pulses
// - Watchdog reset never drives clear pin
// - Supply rise makes power-on pulse
// - Power-up delay counted on RC ticks
// - Core held while power-up timer runs
// - Config bit enables power-up timer
// - 1024 oscillator cycles after power-up delay
// - Start-up count crystal modes, power-on/wake
// - Config bit enables supply drop reset
// - Drop longer than minimum duration resets
// - Hold during drop, then power-up delay
// - Drop during delay restarts sequence
// - Drop enable forces power-up timer
// - Sequence: delay, start-up count, release
// - Clear held from run releases at once; clear held during timeouts restarts them
// - Expiry and sleep flags per cause
// - Power flag cleared only by power-on
// - Supply flag cleared by drop reset
// - Two bits select four oscillator modes
`timescale 1ns/1ps
module reset_timeout_sequencer #(
   parameter int POWER_UP_TICKS = reset_timeout_pkg::POWER_UP_CYCLES,
   parameter int DROP_MIN       = reset_timeout_pkg::DROP_MIN_CYCLES,
   parameter int OSC_COUNT      = reset_timeout_pkg::OSC_STARTUP_COUNT
)(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        supplyRise,
   input  wire logic        supplyLow,
   input  wire logic        masterClearPinN,
   input  wire logic        watchdogTimeout,
   input  wire logic        sleeping,
   input  wire logic        rcTick,
   input  wire logic        oscTick,
   output logic             coreResetN,
   output logic             stateResetN,
   output logic             masterClearPinOe,
   output logic [2:0]       resetCause,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);
   typedef enum logic [3:0]
   {
      ST_HOLD = 4'b0001,
      ST_POWER_UP_TIMER = 4'b0010,
      ST_OST  = 4'b0100,
      ST_RUN  = 4'b1000
   } seq_t;

   seq_t        state_r;
   logic [3:0]  config_r;
   logic        supplyFlag_r;
   logic        powerFlag_r;
   logic        sleepFlag_r;
   logic        expiryFlag_r;
   logic [31:0] pwrtCnt_r;
   logic [31:0] dropCnt_r;
   logic [10:0] ostCnt_r;
   logic [7:0]  clrCnt_r;
   logic        clrLow_r;
   logic        dropActive_r;
   logic        resetReq;
   logic        wdReset;
   logic        wdWake;
   logic        clrEvent;
   logic        pwrtOn;
   logic        crystal;
   logic [1:0]  oscMode;
   logic        awPend_r;
   logic        wPend_r;
   logic [3:0]  awAddr_r;
   logic [31:0] wData_r;
   logic [3:0]  wStrb_r;

   // Mode select from two config bits
   // mode select
   assign oscMode = {config_r[reset_timeout_pkg::CFG_OSC_HI_BIT],
                     config_r[reset_timeout_pkg::CFG_OSC_LO_BIT]};
   assign crystal = (oscMode != reset_timeout_pkg::MODE_RC);
   // timer enable, forced by drop enable
   assign pwrtOn = config_r[reset_timeout_pkg::CFG_POWER_UP_TIMER_EN_BIT] |
                   config_r[reset_timeout_pkg::CFG_DROP_EN_BIT];
   assign wdReset = watchdogTimeout & ~sleeping & (state_r == ST_RUN);
   assign wdWake  = watchdogTimeout & sleeping & (state_r == ST_RUN);
   assign clrEvent = clrLow_r;
   assign resetReq = supplyRise | clrLow_r | dropActive_r | wdReset;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         clrCnt_r <= 8'h00;
         clrLow_r <= 1'b0;
      end
      else if (masterClearPinN)
      begin
         clrCnt_r <= 8'h00;
         clrLow_r <= 1'b0;
      end
      else if (clrCnt_r < 8'(reset_timeout_pkg::CLEAR_FILTER_CYC))
         clrCnt_r <= clrCnt_r + 8'h01;
      else
         clrLow_r <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         dropCnt_r    <= 32'h00000000;
         dropActive_r <= 1'b0;
      end
      else if (!supplyLow || !config_r[reset_timeout_pkg::CFG_DROP_EN_BIT])
      begin
         dropCnt_r    <= 32'h00000000;
         dropActive_r <= 1'b0;
      end
      else if (dropActive_r || dropCnt_r >= 32'(DROP_MIN))
         dropActive_r <= 1'b1;
      else
         dropCnt_r <= dropCnt_r + 32'h00000001;
   end

   // Start-up sequencer
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         state_r   <= ST_HOLD;
         pwrtCnt_r <= 32'h00000000;
         ostCnt_r  <= 11'h000;
      end
      else if (resetReq)
      begin
         // drop during delay restarts from cleared timer
         pwrtCnt_r <= 32'h00000000;
         ostCnt_r  <= 11'h000;
         if (supplyRise || dropActive_r)
            state_r <= pwrtOn ? ST_POWER_UP_TIMER : (crystal ? ST_OST : ST_RUN);
         else if (state_r == ST_RUN || state_r == ST_HOLD)
            state_r <= ST_HOLD;
      end
      else if (wdWake)
      begin
         // wake from sleep reruns start-up count
         ostCnt_r <= 11'h000;
         state_r  <= crystal ? ST_OST : ST_RUN;
      end
      else
      begin
         case (state_r)
            ST_HOLD:
               // clear released after timeouts runs at once
               state_r <= ST_RUN;
            ST_POWER_UP_TIMER:
               if (pwrtCnt_r >= 32'(POWER_UP_TICKS))
                  state_r <= crystal ? ST_OST : ST_RUN;
               else if (rcTick)
                  pwrtCnt_r <= pwrtCnt_r + 32'h00000001;
            ST_OST:
               if (ostCnt_r >= 11'(OSC_COUNT))
                  state_r <= ST_RUN;
               else if (oscTick)
                  ostCnt_r <= ostCnt_r + 11'h001;
            ST_RUN:
               state_r <= ST_RUN;
            default:
               state_r <= ST_HOLD;
         endcase
      end
   end

   // core held until run, released on clock edge
   always_ff @(posedge clk)
   begin
      if (rst)
         coreResetN <= 1'b0;
      else
         coreResetN <= (state_r == ST_RUN) & ~resetReq;
   end

   // state reset on all causes but watchdog wake; preserved state uses none
   always_ff @(posedge clk)
   begin
      if (rst)
         stateResetN <= 1'b0;
      else
         stateResetN <= ~resetReq;
   end

   // watchdog never drives the pin; enable high means released
   always_ff @(posedge clk)
   begin
      if (rst)
         masterClearPinOe <= 1'b1;
      else
         masterClearPinOe <= 1'b1;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         resetCause   <= reset_timeout_pkg::CAUSE_POWER_ON;
         expiryFlag_r <= 1'b1;
         sleepFlag_r  <= 1'b1;
      end
      else if (supplyRise)
      begin
         resetCause   <= reset_timeout_pkg::CAUSE_POWER_ON;
         expiryFlag_r <= 1'b1;
         sleepFlag_r  <= 1'b1;
      end
      else if (dropActive_r)
      begin
         resetCause   <= reset_timeout_pkg::CAUSE_SUPPLY;
         expiryFlag_r <= 1'b1;
         sleepFlag_r  <= 1'b1;
      end
      else if (wdReset)
      begin
         resetCause   <= reset_timeout_pkg::CAUSE_WD_RESET;
         expiryFlag_r <= 1'b0;
         sleepFlag_r  <= 1'b1;
      end
      else if (wdWake)
      begin
         resetCause   <= reset_timeout_pkg::CAUSE_WD_WAKE;
         expiryFlag_r <= 1'b0;
         sleepFlag_r  <= 1'b0;
      end
      else if (clrEvent && state_r == ST_RUN)
      begin
         if (sleeping)
         begin
            resetCause  <= reset_timeout_pkg::CAUSE_CLR_SLEEP;
            expiryFlag_r <= 1'b1;
            sleepFlag_r <= 1'b0;
         end
         else
            resetCause <= reset_timeout_pkg::CAUSE_CLR_RUN;
      end
   end

   // AXI write channel capture, either order
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         awPend_r <= 1'b0;
         wPend_r  <= 1'b0;
         awAddr_r <= 4'h0;
         wData_r  <= 32'h00000000;
         wStrb_r  <= 4'h0;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            awPend_r <= 1'b1;
            awAddr_r <= s_axi_awaddr[3:0];
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            wPend_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
         end
         if (awPend_r && wPend_r && !s_axi_bvalid)
         begin
            awPend_r <= 1'b0;
            wPend_r  <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end
      else
      begin
         s_axi_awready <= ~awPend_r & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready  <= ~wPend_r & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
      end
   end

   // Register writes and status flags; power-on clear wins over software set
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= reset_timeout_pkg::RESP_OKAY;
         config_r     <= reset_timeout_pkg::CFG_RESET;
         powerFlag_r  <= 1'b0;
         supplyFlag_r <= 1'b0;
      end
      else
      begin
         if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
         if (awPend_r && wPend_r && !s_axi_bvalid)
         begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reset_timeout_pkg::RESP_OKAY;
            if (awAddr_r == reset_timeout_pkg::OFF_CONFIG && wStrb_r[0])
               config_r <= wData_r[3:0];
            else if (awAddr_r == reset_timeout_pkg::OFF_STATUS && wStrb_r[0])
            begin
               if (wData_r[reset_timeout_pkg::ST_SUPPLY_BIT])
                  supplyFlag_r <= 1'b1;
               if (wData_r[reset_timeout_pkg::ST_POWER_BIT])
                  powerFlag_r <= 1'b1;
            end
            else if (awAddr_r != reset_timeout_pkg::OFF_STATUS &&
                     awAddr_r != reset_timeout_pkg::OFF_CONFIG)
               s_axi_bresp <= reset_timeout_pkg::RESP_SLVERR;
         end
         // power flag cleared by power-on only
         if (supplyRise)
            powerFlag_r <= 1'b0;
         // supply flag cleared by drop reset
         if (dropActive_r)
            supplyFlag_r <= 1'b0;
      end
   end

   // Read channel
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= reset_timeout_pkg::RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= reset_timeout_pkg::RESP_OKAY;
            case (s_axi_araddr[3:0])
               reset_timeout_pkg::OFF_CONFIG:
                  s_axi_rdata <= {28'h0000000, config_r};
               reset_timeout_pkg::OFF_STATUS:
                  s_axi_rdata <= {27'h0000000, (state_r == ST_RUN), expiryFlag_r,
                                  sleepFlag_r, powerFlag_r, supplyFlag_r};
               reset_timeout_pkg::OFF_CAUSE:
                  s_axi_rdata <= {29'h00000000, resetCause};
               default:
               begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= reset_timeout_pkg::RESP_SLVERR;
               end
            endcase
         end
      end
   end
endmodule

// File: verif/far_side_model.sv
// Far-side model: clear pin with pull-up, supply detectors, RC and crystal ticks.
// Assumes the bench steers holdClear, dropNow and riseNow just after clock edges.
`timescale 1ns/1ps
module far_side_model (
   input  wire logic clk,
   input  wire logic holdClear,
   input  wire logic dropNow,
   input  wire logic riseNow,
   input  wire logic pinOe,
   output logic      masterClearPinN,
   output logic      supplyLow,
   output logic      supplyRise,
   output logic      rcTick,
   output logic      oscTick
);
   logic [1:0] divCnt_r = 2'h0;
   // held clear pin
   // Pull-up wins when nobody drives, so the pin never floats
   assign masterClearPinN = !holdClear && (pinOe !== 1'b0);
   assign supplyLow = dropNow;
   assign supplyRise = riseNow;
   // Free-running ticks; RC ticks slow so delays span many cycles
   always_ff @(posedge clk)
      divCnt_r <= divCnt_r + 2'h1;
   assign rcTick = (divCnt_r == 2'h3);
   assign oscTick = divCnt_r[0];
endmodule

// File: verif/reset_timeout_checker_checker.sv
// Port assertions for the reset sequencer.
// Assumes rcTick is never closer than four cycles apart.
`timescale 1ns/1ps
module reset_timeout_checker (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       supplyRise,
   input wire logic       supplyLow,
   input wire logic       masterClearPinN,
   input wire logic       watchdogTimeout,
   input wire logic       sleeping,
   input wire logic       coreResetN,
   input wire logic       stateResetN,
   input wire logic       masterClearPinOe,
   input wire logic [2:0] resetCause
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_pinFree;
      masterClearPinOe;
   endproperty
   a_pinFree: assert property (p_pinFree) else $error("clear pin driven");
   property p_glitch;
      coreResetN && $fell(masterClearPinN) ##1 !masterClearPinN[*4] ##1 masterClearPinN
      |=> coreResetN[*4];
   endproperty
   a_glitch: assert property (p_glitch) else $error("glitch reset core");
   property p_wdReset;
      watchdogTimeout && !sleeping && coreResetN |-> ##[1:2] !stateResetN;
   endproperty
   a_wdReset: assert property (p_wdReset) else $error("no state reset");
   property p_wdCause;
      watchdogTimeout && !sleeping && coreResetN
      |-> ##[1:3] resetCause == reset_timeout_pkg::CAUSE_WD_RESET;
   endproperty
   a_wdCause: assert property (p_wdCause) else $error("bad watchdog cause");
   property p_wdWake;
      watchdogTimeout && sleeping && coreResetN |=> stateResetN[*4];
   endproperty
   a_wdWake: assert property (p_wdWake) else $error("wake reset state");
   property p_powerOn;
      supplyRise |-> ##[1:2] (!coreResetN && resetCause == reset_timeout_pkg::CAUSE_POWER_ON);
   endproperty
   a_powerOn: assert property (p_powerOn) else $error("no power-on reset");
   property p_dropHold;
      supplyLow && !coreResetN && resetCause == reset_timeout_pkg::CAUSE_SUPPLY |=> !coreResetN;
   endproperty
   a_dropHold: assert property (p_dropHold) else $error("left drop reset");
   property p_dropDelay;
      $fell(supplyLow) && !coreResetN && resetCause == reset_timeout_pkg::CAUSE_SUPPLY
      |-> !coreResetN[*8];
   endproperty
   a_dropDelay: assert property (p_dropDelay) else $error("no delay after drop");
   property p_clrRelease;
      $rose(masterClearPinN) && !coreResetN && resetCause == reset_timeout_pkg::CAUSE_CLR_RUN
      |-> ##[1:4] coreResetN;
   endproperty
   a_clrRelease: assert property (p_clrRelease) else $error("slow release");
   c_drop: cover property (supplyLow && resetCause == reset_timeout_pkg::CAUSE_SUPPLY);
   c_wake: cover property (watchdogTimeout && sleeping && coreResetN);
   c_clear: cover property ($rose(masterClearPinN) && !coreResetN);
endmodule
bind reset_timeout_sequencer reset_timeout_checker i_reset_timeout_checker (
   .clk, .rst, .supplyRise, .supplyLow, .masterClearPinN, .watchdogTimeout, .sleeping,
   .coreResetN, .stateResetN, .masterClearPinOe, .resetCause);

// File: verif/tb_top.sv
// Self-checking bench: sequencer, far-side model and an AXI4-Lite master.
// Assumes shortened counts so each start-up takes tens of cycles.
`timescale 1ns/1ps
module tb_top;
   localparam int PU = 8;
   localparam int DM = 4;
   localparam int OC = 4;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic holdClear = 1'b0, dropNow = 1'b0, riseNow = 1'b0;
   logic watchdogTimeout = 1'b0, sleeping = 1'b0;
   logic supplyRise, supplyLow, masterClearPinN, rcTick, oscTick;
   logic coreResetN, stateResetN, masterClearPinOe;
   logic [2:0] resetCause;
   logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
   logic [31:0] rd;
   int n_mismatch = 0;
   int comparisons = 0;
   int n;
   always #5 clk = ~clk;
   far_side_model i_far_side_model (.clk, .holdClear, .dropNow, .riseNow,
      .pinOe(masterClearPinOe), .masterClearPinN, .supplyLow, .supplyRise, .rcTick, .oscTick);
   reset_timeout_sequencer #(.POWER_UP_TICKS(PU), .DROP_MIN(DM), .OSC_COUNT(OC))
   i_reset_timeout_sequencer (.clk, .rst, .supplyRise, .supplyLow, .masterClearPinN,
      .watchdogTimeout, .sleeping, .rcTick, .oscTick, .coreResetN, .stateResetN,
      .masterClearPinOe, .resetCause, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int k);
      repeat (k) @(posedge clk);
   endtask
   // Both channels offered together, each released when taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      int t;
      t = 0;
      s_axi_awaddr <= {28'h0, a};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge clk);
         t++;
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      end
      while (s_axi_bvalid !== 1'b1 && t < 40);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
      // One idle edge keeps back-to-back calls from driving bready twice at once
      @(posedge clk);
      if (t >= 40) n_mismatch++;
   endtask
   task automatic rdr(input logic [3:0] a);
      int t;
      t = 0;
      s_axi_araddr <= {28'h0, a};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge clk);
         t++;
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      end
      while (s_axi_rvalid !== 1'b1 && t < 40);
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge clk);
      if (t >= 40) n_mismatch++;
   endtask
   // First look one edge on, so the release launched by the last source is seen
   task automatic waitCore();
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (coreResetN !== 1'b1 && n < 300);
      chk(coreResetN, 1'b1);
   endtask
   task automatic t_power();
      rdr(reset_timeout_pkg::OFF_CONFIG);
      chk(rd, 32'h0);
      rdr(4'hC);
      chk(rsp, reset_timeout_pkg::RESP_SLVERR);
      wr(4'hC, 32'h0);
      chk(rsp, reset_timeout_pkg::RESP_SLVERR);
      wr(reset_timeout_pkg::OFF_CONFIG, 32'h7);
      chk(rsp, reset_timeout_pkg::RESP_OKAY);
      riseNow <= 1'b1;
      cyc(1);
      riseNow <= 1'b0;
      waitCore();
      chk(n >= PU * 4 - 4 && n < PU * 4 + 6, 1'b1);
      rdr(reset_timeout_pkg::OFF_STATUS);
      chk(rd[3:1], 3'b110);
      wr(reset_timeout_pkg::OFF_STATUS, 32'h3);
      $display("power test done");
   endtask
   task automatic t_drop();
      wr(reset_timeout_pkg::OFF_CONFIG, 32'h9);
      dropNow <= 1'b1;
      cyc(2);
      dropNow <= 1'b0;
      cyc(6);
      chk(coreResetN, 1'b1);
      dropNow <= 1'b1;
      cyc(DM + 8);
      chk(coreResetN, 1'b0);
      dropNow <= 1'b0;
      cyc(16);
      dropNow <= 1'b1;
      cyc(DM + 4);
      dropNow <= 1'b0;
      waitCore();
      chk(n >= PU * 4 + OC * 2 - 6 && n < PU * 4 + OC * 2 + 16, 1'b1);
      rdr(reset_timeout_pkg::OFF_CAUSE);
      chk(rd, reset_timeout_pkg::CAUSE_SUPPLY);
      rdr(reset_timeout_pkg::OFF_STATUS);
      chk(rd[1:0], 2'b10);
      $display("drop test done");
   endtask
   task automatic t_clear(input logic slp, input logic [2:0] cause);
      holdClear <= 1'b1;
      cyc(5);
      holdClear <= 1'b0;
      cyc(6);
      chk(coreResetN, 1'b1);
      sleeping <= slp;
      holdClear <= 1'b1;
      cyc(20);
      chk(coreResetN, 1'b0);
      holdClear <= 1'b0;
      sleeping <= 1'b0;
      waitCore();
      chk(n <= 5, 1'b1);
      rdr(reset_timeout_pkg::OFF_CAUSE);
      chk(rd, cause);
      rdr(reset_timeout_pkg::OFF_STATUS);
      chk(rd[1], 1'b1);
      if (slp) chk(rd[2], 1'b0);
      $display("clear test done");
   endtask
   task automatic t_watchdog();
      watchdogTimeout <= 1'b1;
      cyc(1);
      watchdogTimeout <= 1'b0;
      cyc(2);
      waitCore();
      rdr(reset_timeout_pkg::OFF_STATUS);
      chk(rd[3:2], 2'b01);
      sleeping <= 1'b1;
      cyc(2);
      watchdogTimeout <= 1'b1;
      cyc(1);
      watchdogTimeout <= 1'b0;
      sleeping <= 1'b0;
      cyc(2);
      chk(coreResetN, 1'b0);
      waitCore();
      rdr(reset_timeout_pkg::OFF_CAUSE);
      chk(rd, reset_timeout_pkg::CAUSE_WD_WAKE);
      rdr(reset_timeout_pkg::OFF_STATUS);
      chk(rd[3:2], 2'b00);
      $display("watchdog test done");
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial
   begin
      cyc(6);
      rst <= 1'b0;
      cyc(1);
      t_power();
      t_drop();
      t_clear(1'b0, reset_timeout_pkg::CAUSE_CLR_RUN);
      t_clear(1'b1, reset_timeout_pkg::CAUSE_CLR_SLEEP);
      t_watchdog();
      complete_run();
   end
   // Whole run needs well under two thousand cycles
   initial
   begin
      #200000;
      n_mismatch++;
      complete_run();
   end
endmodule
